/* src/dvip_pkg.sv */
// constants shared by the digital video input port design
// assumes a 50 MHz system clock and a 32-bit register bus
package dvip_pkg;
	// register byte offsets
	localparam logic [7:0] DVIP_OFF_DVI = 8'h00;
	localparam logic [7:0] DVIP_OFF_TGC = 8'h04;
	localparam logic [7:0] DVIP_OFF_TGD = 8'h08;
	localparam logic [7:0] DVIP_OFF_DMA = 8'h0C;
	localparam logic [7:0] DVIP_OFF_TGE = 8'h10;
	localparam logic [7:0] DVIP_OFF_STA = 8'h14;
	// field positions
	localparam int DVIP_FMT_LSB = 0;
	localparam int DVIP_ALN_LSB = 4;
	localparam int DVIP_SOE_BIT = 6;
	localparam int DVIP_RW_BIT = 0;
	localparam int DVIP_AR_BIT = 1;
	localparam int DVIP_SEL_LSB = 10;
	localparam int DVIP_EN_BIT = 0;
	// reset values
	localparam logic [6:0] DVIP_DVI_RST = 7'h00;
	localparam logic [2:0] DVIP_SEL_RST = 3'h0;
	// codes
	localparam logic [2:0] DVIP_SEL_PORT = 3'h4;
	localparam logic [2:0] DVIP_FMT_EXT = 3'h0;
	localparam logic [2:0] DVIP_FMT_656 = 3'h1;
	localparam logic [2:0] DVIP_FMT_125 = 3'h2;
	localparam logic [1:0] DVIP_CK_PORT = 2'h0;
	localparam logic [1:0] DVIP_CK_PLL = 2'h1;
	localparam logic [1:0] DVIP_CK_XTAL = 2'h2;
	// line layout in bytes
	localparam logic [11:0] DVIP_LINE_525 = 12'd1716;
	localparam logic [11:0] DVIP_LINE_625 = 12'd1728;
	localparam logic [11:0] DVIP_BLANK_525 = 12'd276;
	localparam logic [11:0] DVIP_BLANK_625 = 12'd288;
	localparam logic [11:0] DVIP_HS_525 = 12'd32;
	localparam logic [11:0] DVIP_HS_625 = 12'd24;
	localparam logic [11:0] DVIP_ACT_656 = 12'd1440;
	localparam logic [11:0] DVIP_BLOCK_656 = 12'd1448;
	localparam logic [11:0] DVIP_ACT_125 = 12'd1280;
	localparam logic [11:0] DVIP_LINE_125 = 12'd1560;
	localparam logic [11:0] DVIP_REF_LEN = 12'd4;
	// port clock loss: longest legal port clock period
	localparam int DVIP_PORT_MAX_NS = 10000;
	localparam int DVIP_CLK_NS = 20;
	localparam int DVIP_LOSS_CYC = DVIP_PORT_MAX_NS / DVIP_CLK_NS;
	// timing program memory
	localparam int DVIP_TG_AW = 6;
	localparam int DVIP_TG_DW = 20;
	localparam logic [5:0] DVIP_TG_VSTART = 6'h20;
	typedef enum logic [1:0] {DVIP_SEQ_IDLE, DVIP_SEQ_FETCH, DVIP_SEQ_RUN} dvip_seq_t;
endpackage : dvip_pkg

/* src/dvip_tg_mem.sv */
// timing program memory: one write port, registered read port
// assumes both ports run on the system clock
`timescale 1ns/1ps
`default_nettype none
module dvip_tg_mem import dvip_pkg::*; (
	// clock
	input wire logic clk,
	input wire logic ce,
	// write
	input wire logic we,
	input wire logic [DVIP_TG_AW-1:0] waddr,
	input wire logic [DVIP_TG_DW-1:0] wdata,
	// read
	input wire logic [DVIP_TG_AW-1:0] raddr,
	output logic [DVIP_TG_DW-1:0] rdata
);
	logic [DVIP_TG_DW-1:0] mem [0:(1<<DVIP_TG_AW)-1];

	always_ff @(posedge clk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
		if (ce) begin
			rdata <= mem[raddr];
		end
	end
endmodule : dvip_tg_mem
`default_nettype wire

/* src/dvip_ref_detect.sv */
// finds embedded start/end of active video codes in the byte stream
// and checks line and active lengths; assumes one strobe per byte
`timescale 1ns/1ps
`default_nettype none
module dvip_ref_detect import dvip_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// byte stream
	input wire logic stb,
	input wire logic [7:0] din,
	input wire logic [2:0] fmt,
	// results
	output logic eav,
	output logic sav,
	output logic vbit,
	output logic fbit,
	output logic len_ok
);
	logic [23:0] hist_reg;
	logic [11:0] line_reg;
	logic [11:0] act_reg;
	wire is_ref = stb && (hist_reg == 24'hFF0000);
	wire is_eav = is_ref && din[4];
	wire is_sav = is_ref && !din[4];
	wire is_125 = (fmt == DVIP_FMT_125);
	wire [11:0] line_len = line_reg - 12'd2;
	wire [11:0] act_len = act_reg - (DVIP_REF_LEN - 12'd1);
	// line between two end codes: 1716/1728 bytes, or 1560 in the 125 variant
	wire line_good = is_125 ? (line_len == DVIP_LINE_125) :
		(line_len == DVIP_LINE_525 || line_len == DVIP_LINE_625);
	// active run between the codes: 1440 bytes, 1280 in the 125 variant
	wire act_good = act_len == (is_125 ? DVIP_ACT_125 : DVIP_ACT_656);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hist_reg <= 24'h000000;
			line_reg <= 12'h000;
			act_reg <= 12'h000;
			eav <= 1'b0;
			sav <= 1'b0;
			vbit <= 1'b0;
			fbit <= 1'b0;
			len_ok <= 1'b0;
		end else if (ce) begin
			eav <= is_eav;
			sav <= is_sav;
			if (stb) begin
				hist_reg <= {hist_reg[15:0], din};
				line_reg <= is_eav ? 12'd3 : line_reg + 12'd1;
				act_reg <= is_sav ? 12'h000 : act_reg + 12'd1;
			end
			if (is_eav) begin
				vbit <= din[5];
				fbit <= din[6];
				len_ok <= line_good && act_good;
			end
		end
	end
endmodule : dvip_ref_detect
`default_nettype wire

/* src/dvip_top.sv */
// digital video input port: samples the port, re-times sync events through
// a programmable timing sequencer, drives timing pins and decoder timing
// assumes an AXI4-Lite master and a port clock slower than clk/4
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module dvip_top import dvip_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// general purpose port pins
	input wire logic port_clock,
	input wire logic [23:0] port_in,
	output logic [23:16] port_out,
	output logic [23:16] port_oe,
	// decoder side
	input wire logic pll_sleep,
	output logic [7:0] dec_data,
	output logic dec_valid,
	output logic [1:0] dec_phase,
	output logic [6:0] dec_timing,
	output logic [1:0] dec_clk_sel,
	output logic blue_screen
);
	logic [1:0] rst_sync;
	wire rst_n = rst_sync[1];
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) rst_sync <= 2'b00;
		else rst_sync <= {rst_sync[0], 1'b1};
	end

	// control registers
	logic [6:0] digital_video_interface_reg;
	logic timing_gen_rw_mode;
	logic [2:0] port_dma_control_reg;
	logic timing_gen_enable_reg;
	logic [DVIP_TG_AW-1:0] wptr_reg;
	wire [2:0] video_signal_format = digital_video_interface_reg[DVIP_FMT_LSB +: 3];
	wire [1:0] sync_byte_alignment = digital_video_interface_reg[DVIP_ALN_LSB +: 2];
	wire sync_output_enable = digital_video_interface_reg[DVIP_SOE_BIT];

	// port sampling: two flops, then falling edge of the port clock
	logic [2:0] pclk_s;
	logic [23:0] pin_s1;
	logic [23:0] pin_s2;
	logic [8:0] loss_cnt;
	logic clk_lost;
	logic [1:0] sleep_s;
	wire fall = pclk_s[2] && !pclk_s[1];
	wire port_sel = (port_dma_control_reg == DVIP_SEL_PORT);
	wire video_on = timing_gen_enable_reg && !timing_gen_rw_mode && port_sel && !clk_lost;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pclk_s <= 3'b000;
			pin_s1 <= 24'h000000;
			pin_s2 <= 24'h000000;
			loss_cnt <= 9'h000;
			clk_lost <= 1'b1;
			sleep_s <= 2'b00;
		end else if (ce) begin
			pclk_s <= {pclk_s[1:0], port_clock};
			sleep_s <= {sleep_s[0], pll_sleep};
			pin_s1 <= port_in;
			pin_s2 <= pin_s1;
			loss_cnt <= (pclk_s[2] != pclk_s[1]) ? 9'h000 : loss_cnt + {8'h00, !clk_lost};
			clk_lost <= (pclk_s[2] == pclk_s[1]) &&
				(loss_cnt >= 9'(DVIP_LOSS_CYC - 1));
		end
	end

	// bytes and sync inputs taken at the falling edge
	logic [7:0] byte_reg;
	logic stb_reg;
	logic hs_d;
	logic vs_d;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_reg <= 8'h00;
			stb_reg <= 1'b0;
			hs_d <= 1'b0;
			vs_d <= 1'b0;
		end else if (ce) begin
			stb_reg <= fall;
			if (fall) begin
				byte_reg <= pin_s2[7:0];
				hs_d <= pin_s2[18];
				vs_d <= pin_s2[20];
			end
		end
	end
	wire hs_edge = fall && pin_s2[18] && !hs_d;
	wire vs_edge = fall && pin_s2[20] && !vs_d;

	logic eav;
	logic sav;
	logic vbit;
	logic fbit;
	logic len_ok;
	logic vbit_d;
	dvip_ref_detect u_ref (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.stb(stb_reg),
		.din(byte_reg),
		.fmt(video_signal_format),
		.eav(eav),
		.sav(sav),
		.vbit(vbit),
		.fbit(fbit),
		.len_ok(len_ok)
	);
	// embedded formats take line and field starts from the end code
	wire embedded = (video_signal_format == DVIP_FMT_656) ||
		(video_signal_format == DVIP_FMT_125);
	wire h_evt = video_on && (embedded ? eav : hs_edge);
	wire v_evt = video_on && (embedded ? (eav && vbit && !vbit_d) : vs_edge);

	// sequencer over the timing program
	dvip_seq_t state;
	logic [DVIP_TG_AW-1:0] rptr_reg;
	logic [11:0] dur_reg;
	logic [6:0] tim_reg;
	logic [DVIP_TG_DW-1:0] entry;
	logic [1:0] phase_reg;
	logic mem_we;
	wire last = entry[19];
	// memory is addressed with the pointer being loaded, so the fetch sees fresh data
	wire seq_adv = (state == DVIP_SEQ_RUN) && stb_reg && (dur_reg == 12'h000);
	wire [DVIP_TG_AW-1:0] rptr_next = !video_on ? rptr_reg : h_evt ? '0 :
		v_evt ? DVIP_TG_VSTART : seq_adv ? (last ? '0 : rptr_reg + 1'b1) : rptr_reg;
	dvip_tg_mem u_mem (
		.clk(clk),
		.ce(ce),
		.we(mem_we),
		.waddr(wptr_reg),
		.wdata(wdata_q[DVIP_TG_DW-1:0]),
		.raddr(rptr_next),
		.rdata(entry)
	);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= DVIP_SEQ_IDLE;
			rptr_reg <= '0;
			dur_reg <= 12'h000;
			tim_reg <= 7'h00;
			vbit_d <= 1'b0;
		end else if (ce) begin
			if (eav) vbit_d <= vbit;
			if (!video_on) begin
				state <= DVIP_SEQ_IDLE;
				tim_reg <= 7'h00;
			end else if (h_evt || v_evt) begin
				rptr_reg <= h_evt ? '0 : DVIP_TG_VSTART;
				state <= DVIP_SEQ_FETCH;
			end else begin
				case (state)
				DVIP_SEQ_FETCH: begin
					dur_reg <= entry[18:7];
					tim_reg <= entry[6:0];
					state <= DVIP_SEQ_RUN;
				end
				DVIP_SEQ_RUN: begin
					if (stb_reg && dur_reg == 12'h000) begin
						rptr_reg <= last ? '0 : rptr_reg + 1'b1;
						state <= DVIP_SEQ_FETCH;
					end else if (stb_reg) begin
						dur_reg <= dur_reg - 12'd1;
					end
				end
				default: state <= DVIP_SEQ_IDLE;
				endcase
			end
		end
	end

	// pins and decoder outputs: port_out at the port falling edge, decoder bytes one cycle later, the rest every cycle
	logic pix_reg;
	logic line_start_reg;
	wire oe_on = port_sel && timing_gen_enable_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pix_reg <= 1'b0;
			line_start_reg <= 1'b0;
			dec_phase <= 2'b00;
			port_out <= 8'h00;
			port_oe <= 8'h00;
			dec_data <= 8'h00;
			dec_valid <= 1'b0;
			phase_reg <= 2'b00;
			dec_timing <= 7'h00;
			dec_clk_sel <= DVIP_CK_PLL;
			blue_screen <= 1'b1;
		end else if (ce) begin
			// decoder clock: port when selected and alive, else fallback
			dec_clk_sel <= (port_sel && !clk_lost) ? DVIP_CK_PORT :
				(sleep_s[1] ? DVIP_CK_XTAL : DVIP_CK_PLL);
			blue_screen <= !port_sel || clk_lost || !timing_gen_enable_reg;
			dec_valid <= stb_reg && video_on;
			dec_timing <= tim_reg;
			// end code is reported a cycle after its strobe: hold it for the next byte
			if (h_evt) line_start_reg <= 1'b1;
			else if (stb_reg) line_start_reg <= 1'b0;
			if (stb_reg) begin
				dec_data <= byte_reg;
				// byte phase Cb,Y0,Cr,Y1; Cb,Y,Cr co-sited
				phase_reg <= (line_start_reg ? sync_byte_alignment : phase_reg) + 2'd1;
				dec_phase <= line_start_reg ? sync_byte_alignment : phase_reg;
			end
			if (fall) begin
				pix_reg <= video_on ? !pix_reg : 1'b0;
				port_out <= {video_on && !pix_reg, tim_reg};
			end
			// bits 20 and 18 are inputs unless sync output is enabled
			port_oe <= {oe_on, oe_on, oe_on, oe_on && sync_output_enable, oe_on,
				oe_on && sync_output_enable, oe_on, oe_on};
		end
	end

	// AXI4-Lite slave
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire [31:0] wd = wdata_q & wmask;
	wire do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire hit_dvi = awaddr_q == DVIP_OFF_DVI;
	wire hit_tgc = awaddr_q == DVIP_OFF_TGC;
	wire hit_tgd = awaddr_q == DVIP_OFF_TGD;
	wire hit_dma = awaddr_q == DVIP_OFF_DMA;
	wire hit_tge = awaddr_q == DVIP_OFF_TGE;
	wire wr_ok = hit_dvi || hit_tgc || hit_tgd || hit_dma || hit_tge;
	assign mem_we = do_wr && hit_tgd && timing_gen_rw_mode;
	logic [31:0] rd_mux;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == DVIP_OFF_DVI) rd_mux = {25'h0, digital_video_interface_reg};
		else if (s_axi_araddr == DVIP_OFF_TGC) rd_mux = {18'h0, wptr_reg, 7'h0,
			timing_gen_rw_mode};
		else if (s_axi_araddr == DVIP_OFF_TGD) rd_mux = 32'h00000000;
		else if (s_axi_araddr == DVIP_OFF_DMA) rd_mux = {19'h0, port_dma_control_reg, 10'h0};
		else if (s_axi_araddr == DVIP_OFF_TGE) rd_mux = {31'h0, timing_gen_enable_reg};
		else if (s_axi_araddr == DVIP_OFF_STA) rd_mux = {26'h0, state == DVIP_SEQ_RUN,
			fbit, len_ok, clk_lost, dec_clk_sel};
		else begin
			rd_mux = 32'h00000000;
			rd_ok = 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			digital_video_interface_reg <= DVIP_DVI_RST;
			timing_gen_rw_mode <= 1'b0;
			port_dma_control_reg <= DVIP_SEL_RST;
			timing_gen_enable_reg <= 1'b0;
			wptr_reg <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
				if (hit_dvi) digital_video_interface_reg <= (digital_video_interface_reg &
					~wmask[6:0]) | wd[6:0];
				if (hit_tgc && wstrb_q[0]) begin
					timing_gen_rw_mode <= wdata_q[DVIP_RW_BIT];
					if (wdata_q[DVIP_AR_BIT]) wptr_reg <= '0;
				end
				if (mem_we) wptr_reg <= wptr_reg + 1'b1;
				if (hit_dma && wstrb_q[1]) port_dma_control_reg <=
					wdata_q[DVIP_SEL_LSB +: 3];
				if (hit_tge && wstrb_q[0]) timing_gen_enable_reg <=
					wdata_q[DVIP_EN_BIT];
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// checks
	seq_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !video_on) |=> (state == DVIP_SEQ_IDLE && tim_reg == 7'h00))
		else $error("sequencer active while video mode off");
	h_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && h_evt) |=> (rptr_reg == '0 && state == DVIP_SEQ_FETCH))
		else $error("horizontal event did not restart program");
	v_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && v_evt && !h_evt) |=> rptr_reg == DVIP_TG_VSTART)
		else $error("vertical event did not restart program");
	addr_inc_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && mem_we) |=> wptr_reg == $past(wptr_reg) + 1'b1)
		else $error("timing memory address did not advance");
	clk_port_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && port_sel && !clk_lost) |=> dec_clk_sel == DVIP_CK_PORT)
		else $error("decoder not on port clock");
	clk_fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && clk_lost) |=> dec_clk_sel == ($past(sleep_s[1]) ? DVIP_CK_XTAL : DVIP_CK_PLL))
		else $error("wrong fallback clock");
	pin_change_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !fall) |=> $stable(port_out))
		else $error("timing pin changed away from port falling edge");
	enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && do_wr && hit_tge && wstrb_q[0]) |=> timing_gen_enable_reg == $past(wdata_q[0]))
		else $error("enable bit not written");
	oe_in_a: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !sync_output_enable) |=> (!port_oe[20] && !port_oe[18]))
		else $error("sync input pins driven");
endmodule : dvip_top
`default_nettype wire

/* sim/dvip_src_model.sv */
// video source model: drives the port clock, the byte lanes and the sync pins
// assumes a 160 ns port clock that stands high between frames
`timescale 1ns/1ps
`default_nettype none
module dvip_src_model (
	// port pins
	output var logic port_clock,
	output var logic [23:0] port_in
);
	logic [7:0] sent_q[$];
	initial begin
		port_clock = 1'b1;
		// embedded codes carry the syncs, sync pins stay low
		port_in = 24'h000000;
	end
	// byte changes in the high phase and is sampled by the falling edge
	task automatic send_byte(input logic [7:0] b);
		port_in[7:0] = b;
		#80;
		port_clock = 1'b0;
		sent_q.push_back(b);
		#80;
		port_clock = 1'b1;
	endtask : send_byte
	// released lanes must not keep showing the last byte
	task automatic go_idle();
		port_in[7:0] = ~port_in[7:0];
	endtask : go_idle
endmodule : dvip_src_model
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the digital video input port
// assumes the source model file is compiled before this one
`timescale 1ns/1ps
`default_nettype none
module tb import dvip_pkg::*; ;
	logic clk, resetn, ce, pll_sleep, port_clock;
	logic [23:0] port_in;
	logic [7:0] s_axi_awaddr, s_axi_araddr, dec_data, port_out, port_oe;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, dec_valid, blue_screen;
	logic [1:0] s_axi_bresp, s_axi_rresp, dec_phase, dec_clk_sel, r, aln;
	logic [6:0] dec_timing;
	int n_fail, n_compared, n_pulses, seed_val;
	bit recording;
	logic [31:0] hist_q = 32'h0;
	logic [7:0] b_q;
	logic [1:0] ph = 2'b00;
	bit ph_ok, pk_ok, pk;
	dvip_top dut_u (.clk(clk), .resetn(resetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_clock(port_clock),
		.port_in(port_in), .port_out(port_out), .port_oe(port_oe), .pll_sleep(pll_sleep),
		.dec_data(dec_data), .dec_valid(dec_valid), .dec_phase(dec_phase),
		.dec_timing(dec_timing), .dec_clk_sel(dec_clk_sel), .blue_screen(blue_screen));
	dvip_src_model src_u (.port_clock(port_clock), .port_in(port_in));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		int i;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 64) begin
			check("write wait", 32'd1, 32'd0);
			tally_and_finish();
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 64) begin
			check("read wait", 32'd1, 32'd0);
			tally_and_finish();
		end
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axi_write(a, v, rs);
		check("bresp", 32'(rs), 32'h0);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] rs;
		axi_read(a, v, rs);
		check("rresp", 32'(rs), 32'h0);
		check("register", v, exp);
	endtask : rd_chk
	task automatic send_code(input logic [7:0] xy);
		src_u.send_byte(8'hFF);
		src_u.send_byte(8'h00);
		src_u.send_byte(8'h00);
		src_u.send_byte(xy);
	endtask : send_code
	task automatic send_line(input int act);
		int i;
		send_code(8'h9D);
		for (i = 0; i < int'(DVIP_BLANK_525 - 2 * DVIP_REF_LEN); i++) begin
			src_u.send_byte(i[0] ? 8'h10 : 8'h80);
		end
		send_code(8'h80);
		for (i = 0; i < act; i++) begin
			src_u.send_byte(8'(1 + $urandom_range(253)));
		end
	endtask : send_line
	// reference model: while recording, every decoder byte must be the next byte the source sent
	always @(posedge clk) begin
		if (dec_valid === 1'b1) begin
			n_pulses++;
			if (recording && src_u.sent_q.size() == 0) check("extra byte", 32'd1, 32'd0);
			else if (recording) begin
				b_q = src_u.sent_q.pop_front();
				check("dec_data", 32'(dec_data), 32'(b_q));
				// byte after an end code takes the chosen alignment phase
				if (hist_q[31:8] == 24'hFF0000 && hist_q[4]) begin
					ph = aln;
					ph_ok = 1'b1;
				end else begin
					ph = ph + 2'd1;
				end
				if (ph_ok) check("dec_phase", 32'(dec_phase), 32'(ph));
				hist_q = {hist_q[23:0], b_q};
				if (pk_ok) check("pixel clock", 32'(port_out[7]), 32'(!pk));
				pk = port_out[7];
				pk_ok = 1'b1;
			end
		end
	end
	initial begin
		{resetn, pll_sleep, recording, n_fail, n_compared, n_pulses} = '0;
		ce = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		seed_val = $urandom(32'hD8BEA4AB);
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(DVIP_OFF_DVI, 32'h0);
		rd_chk(DVIP_OFF_TGC, 32'h0);
		rd_chk(DVIP_OFF_DMA, 32'h0);
		rd_chk(DVIP_OFF_TGE, 32'h0);
		axi_read(8'h40, d, r);
		check("unmapped rresp", 32'(r), 32'h2);
		check("unmapped rdata", d, 32'h0);
		axi_write(8'h40, 32'hFFFFFFFF, r);
		check("unmapped bresp", 32'(r), 32'h2);
		aln = 2'($urandom_range(3));
		wr(DVIP_OFF_DVI, {25'h0, 1'b0, aln, 1'b0, DVIP_FMT_656});
		rd_chk(DVIP_OFF_DVI, {25'h0, 1'b0, aln, 1'b0, DVIP_FMT_656});
		wr(DVIP_OFF_TGC, 32'h3);
		wr(DVIP_OFF_TGD, {12'h0, 1'b1, 12'hFFF, 7'h55});
		wr(DVIP_OFF_TGD, 32'h11);
		wr(DVIP_OFF_TGD, 32'h22);
		rd_chk(DVIP_OFF_TGC, 32'h301);
		wr(DVIP_OFF_TGC, 32'h0);
		wr(DVIP_OFF_TGD, 32'h33);
		rd_chk(DVIP_OFF_TGC, 32'h300);
		wr(DVIP_OFF_DMA, {19'h0, DVIP_SEL_PORT, 10'h0});
		send_line(16);
		src_u.go_idle();
		repeat (10) @(posedge clk);
		check("pulses while off", 32'(n_pulses), 32'h0);
		check("timing while off", 32'(dec_timing), 32'h0);
		wr(DVIP_OFF_TGE, 32'h1);
		send_code(8'h80);
		repeat (20) @(posedge clk);
		src_u.sent_q.delete();
		recording = 1'b1;
		send_line(int'(DVIP_ACT_656));
		send_line(int'(DVIP_ACT_656));
		send_code(8'h9D);
		repeat (20) @(posedge clk);
		axi_read(DVIP_OFF_STA, d, r);
		check("length ok", 32'(d[3]), 32'h1);
		check("clock select", 32'(d[1:0]), 32'(DVIP_CK_PORT));
		check("running", 32'(d[5]), 32'h1);
		check("dec_timing", 32'(dec_timing), 32'h55);
		check("port_out", 32'(port_out[6:0]), 32'h55);
		check("port_oe", 32'(port_oe), 32'hEB);
		check("blue off", 32'(blue_screen), 32'h0);
		send_line(int'(DVIP_ACT_656) - 4);
		send_code(8'h9D);
		src_u.go_idle();
		repeat (20) @(posedge clk);
		axi_read(DVIP_OFF_STA, d, r);
		check("short line", 32'(d[3]), 32'h0);
		check("bytes left", 32'(src_u.sent_q.size()), 32'h0);
		repeat (600) @(posedge clk);
		check("fallback", 32'(dec_clk_sel), 32'(DVIP_CK_PLL));
		check("blue on", 32'(blue_screen), 32'h1);
		pll_sleep <= 1'b1;
		repeat (5) @(posedge clk);
		check("crystal", 32'(dec_clk_sel), 32'(DVIP_CK_XTAL));
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
